// ---- design/irab_pkg.sv ----
// Shared constants, types and helpers of the interrupt response and address break block
package irab_pkg;

  // Clock and state timing; one CPU state is one or more system cycles
  localparam int CLK_NS = 4;
  localparam int STATE_NS = 4;
  localparam int CYC_PER_STATE = (STATE_NS + CLK_NS - 1) / CLK_NS;

  // Response-time components in states
  localparam int RES_EXT_STATES = 3;
  localparam int RES_INT_STATES = 2;
  localparam int SI_STATES = 1;
  localparam int SK_STATES = 1;
  localparam int INTERNAL_STATES = 2;
  localparam int MASK_DELAY_STATES = 2;

  // Same components in clock cycles
  localparam int RES_EXT_CYC = RES_EXT_STATES * CYC_PER_STATE;
  localparam int RES_INT_CYC = RES_INT_STATES * CYC_PER_STATE;
  localparam int STACK_CYC = 2 * SK_STATES * CYC_PER_STATE;
  localparam int VEC_NORM_CYC = SI_STATES * CYC_PER_STATE;
  localparam int VEC_ADV_CYC = 2 * SI_STATES * CYC_PER_STATE;
  localparam int FETCH_CYC = 2 * SI_STATES * CYC_PER_STATE;
  localparam int INTERNAL_CYC = INTERNAL_STATES * CYC_PER_STATE;
  localparam int MASK_DELAY_CYC = MASK_DELAY_STATES * CYC_PER_STATE;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BAR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FLAG_BIT = 1;
  localparam int BAR_LSB = 1;
  localparam int BAR_MSB = 23;
  localparam int NORMAL_MSB = 15;

  // Reset values
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_FLAG_RST = 1'b0;
  localparam logic [22:0] BAR_RST = 23'h000000;
  localparam logic MASK_I_RST = 1'b1;
  localparam logic MASK_UI_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESOLVE = 3'b001,
    ST_WAIT = 3'b010,
    ST_STACK = 3'b011,
    ST_VECTOR = 3'b100,
    ST_FETCH = 3'b101,
    ST_INTERNAL = 3'b110
  } irab_state_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_NMI = 3'b001,
    SRC_BRK = 3'b010,
    SRC_EXT = 3'b011,
    SRC_INT = 3'b100
  } irab_src_e;

  // Prefetch as seen by the comparator
  typedef struct packed {
    logic valid;
    logic first_byte;
    logic [23:0] addr;
  } irab_fetch_s;

  // CPU execution status
  typedef struct packed {
    logic insn_done;
    logic ccr_write;
    logic new_i;
    logic new_ui;
    logic byte_move;
    logic word_break;
    logic adv_mode;
    logic intm1;
  } irab_cpu_s;

  // Highest-priority request: bit0 nmi, bit1 break, bit2 external, bit3 internal
  function automatic irab_src_e irab_pick(input logic [3:0] req);
    irab_src_e s;
    s = SRC_NONE;
    if (req[0]) s = SRC_NMI;
    else if (req[1]) s = SRC_BRK;
    else if (req[2]) s = SRC_EXT;
    else if (req[3]) s = SRC_INT;
    return s;
  endfunction : irab_pick

  // Request vector bit of a source
  function automatic logic [3:0] irab_onehot(input irab_src_e s);
    logic [3:0] v;
    v = 4'h0;
    case (s)
      SRC_NMI: v = 4'h1;
      SRC_BRK: v = 4'h2;
      SRC_EXT: v = 4'h4;
      SRC_INT: v = 4'h8;
      default: v = 4'h0;
    endcase
    return v;
  endfunction : irab_onehot

endpackage : irab_pkg

// ---- design/irab_brk_cmp.sv ----
// Address break comparator on CPU instruction prefetch
`timescale 1ns/1ns
module irab_brk_cmp import irab_pkg::*; (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Setup
  input wire logic enable_in,
  input wire logic adv_mode_in,
  input wire logic [22:0] bar_in,
  input wire irab_fetch_s fetch_in,
  // Result
  output logic hit_out
);

  logic addr_eq;

  // Normal mode drops the upper address byte from the compare
  always_comb begin
    if (adv_mode_in) addr_eq = (fetch_in.addr[BAR_MSB:BAR_LSB] == bar_in); // [RL8]
    else addr_eq = (fetch_in.addr[NORMAL_MSB:BAR_LSB] == bar_in[NORMAL_MSB-1:0]); // [RL12]
  end

  // Registered hit; only first bytes of instructions qualify
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) hit_out <= 1'b0;
    else if (ce_in) hit_out <= fetch_in.valid & fetch_in.first_byte & enable_in & addr_eq; // [RL5] [RL9] [RL11]
  end

  a_no_hit_disabled: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && !enable_in |=> !hit_out) else $error("break hit while disabled"); // [RL9]

  a_no_hit_inside: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && !fetch_in.first_byte |=> !hit_out) else $error("hit inside instruction"); // [RL11]

endmodule : irab_brk_cmp

// ---- design/irab_resolve.sv ----
// Priority resolution with source-dependent latency
`timescale 1ns/1ns
module irab_resolve import irab_pkg::*; (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Request side
  input wire logic start_in,
  input wire logic [3:0] req_in,
  // Result
  output logic done_out,
  output irab_src_e src_out
);

  logic busy;
  logic [2:0] cnt;
  logic [2:0] last;

  // Winner captured at start; external pins take one more state than internal sources
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      last <= 3'h0;
      src_out <= SRC_NONE;
    end else if (ce_in) begin
      if (start_in) begin
        busy <= 1'b1;
        cnt <= 3'h0;
        src_out <= irab_pick(req_in);
        if (irab_pick(req_in) == SRC_NMI || irab_pick(req_in) == SRC_EXT)
          last <= 3'(RES_EXT_CYC - 1); // [RL1]
        else last <= 3'(RES_INT_CYC - 1); // [RL1]
      end else if (busy) begin
        cnt <= cnt + 3'h1;
        if (cnt == last) busy <= 1'b0;
      end
    end
  end

  assign done_out = busy & (cnt == last);

  // Counted only while the clock enable runs, since a frozen resolver stretches the wait
  a_resolve_ext: assert property (@(posedge clock_in) disable iff (rst_in)
    start_in && ce_in && req_in[0] ##1 ce_in[*2]
    |-> (!$past(done_out) && !done_out) ##1 done_out)
    else $error("external resolve not three states"); // [RL1]

endmodule : irab_resolve

// ---- design/irab_top.sv ----
// Interrupt response sequencer and address break unit with Avalon-MM registers
//
// How it works
// RL1 - Resolution takes three states for pin requests, two for internal sources.
// RL2 - Entry waits until the executing instruction ends, at least one state.
// RL3 - Entry is stack save, vector fetch, routine prefetch and two internal states.
// RL4 - Each internal-memory fetch or stack access counts one state.
// RL5 - A prefetch of the break address raises a break request.
// RL6 - Accepted break starts handling only after the current instruction completes.
// RL7 - Mask bits never hold back an address break request.
// RL8 - Software loads break address bits 23 to 1; bit 0 not compared.
// RL9 - No break request while the break enable bit is zero; a match flag set before the bit is cleared still drives the request.
// RL10 - A satisfied break sets the match flag, which drives the request.
// RL11 - Only the first byte of an instruction can match.
// RL12 - Normal mode ignores address bits 23 to 16 in the compare.
// RL13 - Software avoids break addresses right after branches or returns.
// RL14 - Requests held through instruction end; a higher one displaces a lower.
// RL15 - After a control register load or logic op, no interrupt accepted.
// RL16 - New mask values from such instructions apply two states later.
// RL17 - Byte-count block move accepts nothing until the move ends.
// RL18 - Word-count block move accepts at a break between transfer cycles.
// RL19 - Software reads then clears pin flags after reset.
// RL20 - Entry in mode 1 sets both mask bits, mode 0 the main one.
// RL21 - Non-maskable and break requests always accepted except reset or standby; code also holds them off after control register loads and byte moves.
// RL22 - Match flag stays set until read as one then written zero.
`timescale 1ns/1ns
module irab_top import irab_pkg::*; (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic standby_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Interrupt sources
  input wire logic nmi_in,
  input wire logic ext_req_in,
  input wire logic ext_level1_in,
  input wire logic int_req_in,
  // CPU side
  input wire irab_fetch_s fetch_in,
  input wire irab_cpu_s cpu_in,
  output irab_state_e phase_out,
  output irab_src_e src_out,
  output logic mask_i_out,
  output logic mask_ui_out,
  output logic brk_req_out
);

  irab_state_e state;
  irab_src_e src;
  irab_src_e res_src;
  irab_src_e final_src;
  logic [4:0] cnt;
  logic [4:0] vec_last;
  logic [3:0] elig;
  logic res_start;
  logic res_done;
  logic accept;
  logic hit;
  logic brk_en;
  logic brk_flag;
  logic brk_taken;
  logic clr_armed;
  logic [22:0] bar;
  logic ack;
  logic wr_ok;
  logic rd_ok;
  logic [MASK_DELAY_CYC-1:0] md_v;
  logic [MASK_DELAY_CYC-1:0] md_i;
  logic [MASK_DELAY_CYC-1:0] md_ui;
  logic flag_wr_zero;

  // Comparator
  irab_brk_cmp u_cmp (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .enable_in(brk_en),
    .adv_mode_in(cpu_in.adv_mode),
    .bar_in(bar),
    .fetch_in(fetch_in),
    .hit_out(hit)
  );

  // Priority resolver
  irab_resolve u_res (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(res_start),
    .req_in(elig),
    .done_out(res_done),
    .src_out(res_src)
  );

  // Bus handshake: one wait state, so every access answers on its second cycle
  // A frozen cycle keeps the master waiting, else a write could be lost
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~(ack & ce_in);
  assign wr_ok = avs_write_in & ack;
  assign rd_ok = avs_read_in & ~ack;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) ack <= 1'b0;
    else if (ce_in) ack <= (avs_read_in | avs_write_in) & ~ack;
  end

  // Read data captured ahead of the answering edge; unmapped words read zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) avs_readdata_out <= 32'h00000000;
    else if (ce_in && rd_ok) begin
      case (avs_address_in)
        REG_CTRL: avs_readdata_out <= {30'h00000000, brk_flag, brk_en};
        REG_BAR: avs_readdata_out <= {8'h00, bar, 1'b0}; // [RL8]
        REG_STAT: avs_readdata_out <= {24'h000000, mask_ui_out, mask_i_out, src, state};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // Break enable and break address
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      brk_en <= CTRL_EN_RST;
      bar <= BAR_RST;
    end else if (ce_in && wr_ok) begin
      if (avs_address_in == REG_CTRL && avs_byteenable_in[0])
        brk_en <= avs_writedata_in[CTRL_EN_BIT]; // [RL9]
      if (avs_address_in == REG_BAR) begin
        // Bit 0 of the word is not part of the compared address
        if (avs_byteenable_in[0]) bar[6:0] <= avs_writedata_in[7:1]; // [RL8]
        if (avs_byteenable_in[1]) bar[14:7] <= avs_writedata_in[15:8];
        if (avs_byteenable_in[2]) bar[22:15] <= avs_writedata_in[23:16];
      end
    end
  end

  assign flag_wr_zero = wr_ok & (avs_address_in == REG_CTRL) & avs_byteenable_in[0]
                      & ~avs_writedata_in[CTRL_FLAG_BIT];

  // Clear is armed by a read that saw the flag high
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) clr_armed <= 1'b0;
    else if (ce_in) begin
      if (flag_wr_zero) clr_armed <= 1'b0;
      else if (rd_ok && avs_address_in == REG_CTRL && brk_flag) clr_armed <= 1'b1; // [RL22]
    end
  end

  // Match flag: a hit in the clearing cycle wins over the clear
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) brk_flag <= CTRL_FLAG_RST;
    else if (ce_in) begin
      if (hit) brk_flag <= 1'b1; // [RL10]
      else if (flag_wr_zero && clr_armed) brk_flag <= 1'b0; // [RL22]
    end
  end

  // A serviced break is not re-entered until software clears the flag,
  // which would otherwise trap the CPU since masks cannot stop it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) brk_taken <= 1'b0;
    else if (ce_in) begin
      if (accept && final_src == SRC_BRK) brk_taken <= 1'b1;
      else if (!brk_flag) brk_taken <= 1'b0;
    end
  end

  assign brk_req_out = brk_flag & ~brk_taken; // [RL10]

  // Eligible requests after masking; nmi and break ignore both mask bits
  always_comb begin
    elig[0] = nmi_in; // [RL21]
    elig[1] = brk_req_out; // [RL7]
    elig[2] = ext_req_in & (~mask_i_out | (cpu_in.intm1 & ext_level1_in & ~mask_ui_out));
    elig[3] = int_req_in & ~mask_i_out;
  end

  // Held source stays eligible; a newer higher request displaces it
  assign final_src = irab_pick(elig | irab_onehot(src)); // [RL14]

  assign res_start = (state == ST_IDLE) & (|elig) & ~standby_in;

  // Acceptance point: end of an instruction or a word-move transfer gap
  assign accept = (state == ST_WAIT) & ~standby_in
                & ~cpu_in.ccr_write // [RL15]
                & ~cpu_in.byte_move // [RL17]
                & (cpu_in.insn_done | cpu_in.word_break); // [RL2] [RL6] [RL18]

  assign vec_last = cpu_in.adv_mode ? 5'(VEC_ADV_CYC - 1) : 5'(VEC_NORM_CYC - 1); // [RL3]

  // Entry sequencer; standby and reset hold it idle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
    end else if (ce_in) begin
      if (standby_in) begin
        state <= ST_IDLE; // [RL21]
        cnt <= 5'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            if (res_start) state <= ST_RESOLVE;
          end
          ST_RESOLVE: begin
            if (res_done) state <= ST_WAIT; // [RL1]
          end
          ST_WAIT: begin
            if (accept) begin
              state <= ST_STACK;
              cnt <= 5'h00;
            end
          end
          ST_STACK: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'(STACK_CYC - 1)) begin // [RL3] [RL4]
              state <= ST_VECTOR;
              cnt <= 5'h00;
            end
          end
          ST_VECTOR: begin
            cnt <= cnt + 5'h01;
            if (cnt == vec_last) begin // [RL3]
              state <= ST_FETCH;
              cnt <= 5'h00;
            end
          end
          ST_FETCH: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'(FETCH_CYC - 1)) begin // [RL4]
              state <= ST_INTERNAL;
              cnt <= 5'h00;
            end
          end
          ST_INTERNAL: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'(INTERNAL_CYC - 1)) begin // [RL3]
              state <= ST_IDLE;
              cnt <= 5'h00;
            end
          end
          default: begin
            state <= ST_IDLE;
            cnt <= 5'h00;
          end
        endcase
      end
    end
  end

  // Source latched from the resolver, revised at acceptance
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) src <= SRC_NONE;
    else if (ce_in) begin
      if (standby_in) src <= SRC_NONE;
      else if (state == ST_RESOLVE && res_done) src <= res_src;
      else if (accept) src <= final_src; // [RL14]
      else if (state == ST_IDLE) src <= SRC_NONE;
    end
  end

  // Delay line for mask loads from control register instructions
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      md_v <= '0;
      md_i <= '0;
      md_ui <= '0;
    end else if (ce_in) begin
      md_v <= {md_v[MASK_DELAY_CYC-2:0], cpu_in.ccr_write}; // [RL16]
      md_i <= {md_i[MASK_DELAY_CYC-2:0], cpu_in.new_i};
      md_ui <= {md_ui[MASK_DELAY_CYC-2:0], cpu_in.new_ui};
    end
  end

  // Effective masks: entry sets the main mask, in mode 1 both; a delayed load replaces them
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mask_i_out <= MASK_I_RST;
      mask_ui_out <= MASK_UI_RST;
    end else if (ce_in) begin
      if (state == ST_STACK && cnt == 5'h00) begin
        mask_i_out <= 1'b1; // [RL20]
        if (cpu_in.intm1) mask_ui_out <= 1'b1; // [RL20]
      end else if (md_v[MASK_DELAY_CYC-1]) begin
        mask_i_out <= md_i[MASK_DELAY_CYC-1]; // [RL16]
        mask_ui_out <= md_ui[MASK_DELAY_CYC-1];
      end
    end
  end

  assign phase_out = state;
  assign src_out = src;

  a_ccr_blocks_all: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && state == ST_WAIT && cpu_in.ccr_write && !standby_in |=> state == ST_WAIT)
    else $error("interrupt taken after control register instruction"); // [RL15]

  a_byte_move_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && state == ST_WAIT && cpu_in.byte_move && !standby_in |=> state == ST_WAIT)
    else $error("interrupt taken during byte move"); // [RL17]

  a_entry_normal: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && accept && !cpu_in.adv_mode ##1 (ce_in && !standby_in && !cpu_in.adv_mode)[*7]
    |-> $past(state == ST_STACK, 6) && $past(state == ST_VECTOR, 4)
        && $past(state == ST_FETCH, 2) && state == ST_INTERNAL)
    else $error("normal mode entry sequence length wrong"); // [RL3]

  a_entry_adv_vec: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && state == ST_STACK && cnt == 5'(STACK_CYC - 1) && cpu_in.adv_mode && !standby_in
    ##1 (ce_in && cpu_in.adv_mode && !standby_in)[*2] |=> state == ST_FETCH)
    else $error("advanced vector fetch not two states"); // [RL3]

  a_mask_delay: assert property (@(posedge clock_in) disable iff (rst_in)
    (ce_in && cpu_in.ccr_write ##1 ce_in ##1 ce_in && state != ST_STACK)
    |=> mask_i_out == $past(cpu_in.new_i, 3))
    else $error("mask load not applied two states later"); // [RL16]

  a_mask_hold_early: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && cpu_in.ccr_write && !md_v[0] && !md_v[MASK_DELAY_CYC-1] && state != ST_STACK
    |=> $stable(mask_i_out))
    else $error("mask load applied too early"); // [RL16]

  a_entry_masks: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && state == ST_STACK && cnt == 5'h00 && cpu_in.intm1 && !standby_in
    |=> mask_i_out && mask_ui_out)
    else $error("entry did not set both masks"); // [RL20]

  a_flag_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    brk_flag && !(flag_wr_zero && clr_armed) |=> brk_flag)
    else $error("match flag dropped without software clear"); // [RL22]

  a_hit_sets_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && hit |=> brk_flag && brk_req_out | brk_taken)
    else $error("break hit did not set the flag"); // [RL10]

  a_brk_unmasked: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && state == ST_IDLE && brk_req_out && !standby_in |=> state == ST_RESOLVE)
    else $error("break request not taken with masks set"); // [RL7]

  a_standby_idle: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && standby_in |=> state == ST_IDLE)
    else $error("sequencer active in standby"); // [RL21]

endmodule : irab_top

// ---- tb/irab_cpu_model.sv ----
// CPU-side partner: instruction stream, prefetch and control register loads
`timescale 1ns/1ns
module irab_cpu_model import irab_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Bench controls
  input wire logic jump_in,
  input wire logic [23:0] target_in,
  input wire logic [3:0] len_in,
  input wire logic adv_in,
  input wire logic intm1_in,
  input wire logic move_in,
  input wire logic ccr_go_in,
  input wire logic [1:0] ccr_val_in,
  // Toward the block
  output irab_fetch_s fetch_out,
  output irab_cpu_s cpu_out
);
  logic [23:0] pc;
  logic [3:0] cnt;
  logic ccr_pend;
  logic last;
  assign last = (cnt == 4'h0);
  // Prefetch of the next opcode in the last cycle; the bus shows noise between fetches
  assign fetch_out = {last, last, last ? pc + 24'h2 : ~pc};
  // Word-count moves are not modelled, so no transfer gaps are reported
  assign cpu_out = {last, last & ccr_pend, ccr_val_in, move_in, 1'b0, adv_in, intm1_in};
  // Program counter, instruction length and pending control register load
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pc <= 24'h0;
      cnt <= 4'h3;
      ccr_pend <= 1'b0;
    end else begin
      if (jump_in)
        pc <= target_in;
      else if (last)
        pc <= pc + 24'h2;
      cnt <= last ? len_in : cnt - 4'h1;
      if (ccr_go_in)
        ccr_pend <= 1'b1;
      else if (last)
        ccr_pend <= 1'b0;
    end
  end
endmodule : irab_cpu_model

// ---- tb/irab_top_bench.sv ----
// Self-checking bench of the interrupt response and address break block
`timescale 1ns/1ns
module irab_top_bench import irab_pkg::*;;
  logic clock_in, rst_in, avs_read_in, avs_write_in, nmi_in, ext_req_in, int_req_in;
  logic avs_waitrequest_out, mask_i_out, mask_ui_out, brk_req_out;
  logic [3:0] avs_address_in, len, nres, ntail;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  irab_fetch_s fetch_in;
  irab_cpu_s cpu_in;
  irab_state_e phase_out;
  irab_src_e src_out, src_q;
  logic jump, adv, intm1, move, ccr_go, stby, lvl1;
  logic [1:0] ccr_val;
  logic [23:0] target, a, f;
  int n_mismatch, checked;
  logic [31:0] rq[$];
  logic [31:0] eq[$];

  irab_top u_irab_top(.clock_in, .rst_in, .ce_in(1'b1), .standby_in(stby), .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out,
    .avs_waitrequest_out, .nmi_in, .ext_req_in, .ext_level1_in(lvl1), .int_req_in, .fetch_in,
    .cpu_in, .phase_out, .src_out, .mask_i_out, .mask_ui_out, .brk_req_out);
  irab_cpu_model u_irab_cpu_model(.clock_in, .rst_in, .jump_in(jump), .target_in(target),
    .len_in(len), .adv_in(adv), .intm1_in(intm1), .move_in(move), .ccr_go_in(ccr_go),
    .ccr_val_in(ccr_val), .fetch_out(fetch_in), .cpu_out(cpu_in));

  // 250 MHz system clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] ent(input irab_src_e s, input int r, input int t);
    return {21'h0, s, r[3:0], t[3:0]};
  endfunction : ent

  // Read data is taken at the rising edge where waitrequest is sampled low
  always @(posedge clock_in) begin
    if (avs_read_in && !avs_waitrequest_out && rq.size() > 0)
      chk("readdata", rq.pop_front(), avs_readdata_out);
  end

  // Entry monitor at the falling edge, where the registered phase has settled
  always @(negedge clock_in) begin
    if (phase_out == ST_RESOLVE)
      nres = nres + 4'h1;
    if (phase_out == ST_STACK)
      src_q = src_out;
    if (phase_out >= ST_STACK)
      ntail = ntail + 4'h1;
    if (phase_out == ST_IDLE && ntail != 4'h0) begin
      chk("entry", eq.size() > 0 ? eq.pop_front() : 32'hFFFFFFFF, {21'h0, src_q, nres, ntail});
      nres = 4'h0;
      ntail = 4'h0;
    end
  end

  // Avalon transfer: request held until waitrequest is seen low at an edge
  task automatic bus(input logic [3:0] adr, input logic wr, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock_in);
    avs_address_in <= adr;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= d;
    do @(posedge clock_in); while (avs_waitrequest_out && i++ < 20);
    if (i > 20) chk("bus wait", 32'h0, 32'h1);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] adr, input logic [31:0] e);
    rq.push_back(e);
    bus(adr, 1'b0, 32'h0);
  endtask : rd

  // Entry runs to completion; requests are dropped once it has started
  task automatic wait_idle();
    int i;
    i = 0;
    do @(negedge clock_in); while (phase_out == ST_IDLE && i++ < 60);
    @(posedge clock_in);
    nmi_in <= 1'b0;
    ext_req_in <= 1'b0;
    int_req_in <= 1'b0;
    do @(negedge clock_in); while (phase_out != ST_IDLE && i++ < 200);
    if (i >= 200) chk("entry end", 32'h0, 32'h1);
  endtask : wait_idle

  task automatic go(input logic [23:0] t);
    @(posedge clock_in);
    jump <= 1'b1;
    target <= t; // Lands before the break address, never right after a branch
    @(posedge clock_in);
    jump <= 1'b0;
    repeat (30) @(posedge clock_in);
  endtask : go

  // Break hit, service, then read-as-one and write-zero clear of the flag
  task automatic brk(input logic [23:0] t, input int tail);
    eq.push_back(ent(SRC_BRK, 2, tail));
    go(t);
    wait_idle();
    chk("brk_req", 0, brk_req_out);
    rd(REG_CTRL, 32'h3);
    bus(REG_CTRL, 1'b1, 32'h1);
    rd(REG_CTRL, 32'h1);
  endtask : brk

  task automatic ccr_load(input logic [1:0] v);
    @(posedge clock_in);
    ccr_val <= v;
    ccr_go <= 1'b1;
    @(posedge clock_in);
    ccr_go <= 1'b0;
  endtask : ccr_load

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the few hundred cycles of the sequence
  initial begin
    #60000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    int i;
    {rst_in, avs_read_in, avs_write_in, nmi_in, ext_req_in, int_req_in} = 6'h20;
    {jump, adv, intm1, move, ccr_go, stby, lvl1, ccr_val, nres, ntail} = 0;
    {avs_address_in, avs_writedata_in, target} = 0;
    void'($urandom(32'h88B4BB17));
    len = 4'(1 + $urandom() % 5);
    a = {8'hA5, 1'b1, 15'($urandom())};
    a[0] = 1'b1;
    f = {8'h3C, a[15:1], 1'b0};
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(REG_CTRL, 32'h0);
    bus(REG_CTRL, 1'b1, 32'h0);
    rd(REG_STAT, 32'h40);
    rd(4'hC, 32'h0);
    bus(REG_BAR, 1'b1, {8'h0, a});
    rd(REG_BAR, {8'h0, a[23:1], 1'b0});
    bus(REG_CTRL, 1'b1, 32'h1);
    brk(f - 24'h2, 7);
    adv <= 1'b1;
    go(f - 24'h2);
    rd(REG_CTRL, 32'h1);
    bus(REG_CTRL, 1'b1, 32'h0);
    go({a[23:1], 1'b0} - 24'h2);
    rd(REG_CTRL, 32'h0);
    bus(REG_CTRL, 1'b1, 32'h1);
    brk({a[23:1], 1'b0} - 24'h2, 8);
    // Byte-count move holds off even the non-maskable request
    eq.push_back(ent(SRC_NMI, 3, 8));
    @(posedge clock_in);
    nmi_in <= 1'b1;
    move <= 1'b1;
    i = 0;
    do @(negedge clock_in); while (phase_out != ST_WAIT && i++ < 30);
    repeat (12) @(negedge clock_in);
    chk("phase", ST_WAIT, phase_out);
    @(posedge clock_in);
    move <= 1'b0;
    wait_idle();
    // External request waits for the main mask, which clears two states late
    eq.push_back(ent(SRC_EXT, 3, 8));
    @(posedge clock_in);
    ext_req_in <= 1'b1;
    repeat (8) @(negedge clock_in);
    chk("phase", ST_IDLE, phase_out);
    ccr_load(2'b00);
    i = 0;
    do @(negedge clock_in); while (!cpu_in.ccr_write && i++ < 40);
    repeat (2) @(negedge clock_in);
    chk("mask_i", 1, mask_i_out);
    @(negedge clock_in);
    chk("mask_i", 0, mask_i_out);
    wait_idle();
    chk("mask_i", 1, mask_i_out);
    // Mode 1 entry raises both masks
    ccr_load(2'b00);
    intm1 <= 1'b1;
    eq.push_back(ent(SRC_INT, 2, 8));
    int_req_in <= 1'b1;
    wait_idle();
    chk("masks", 2'b11, {mask_i_out, mask_ui_out});
    // Level-1 pin request passes once only the user mask is clear
    ccr_load(2'b10);
    eq.push_back(ent(SRC_EXT, 3, 8));
    lvl1 <= 1'b1;
    ext_req_in <= 1'b1;
    wait_idle();
    chk("masks", 2'b11, {mask_i_out, mask_ui_out});
    // Standby keeps the sequencer idle even for the non-maskable request
    @(posedge clock_in);
    stby <= 1'b1;
    nmi_in <= 1'b1;
    repeat (6) @(negedge clock_in);
    chk("phase", ST_IDLE, phase_out);
    @(posedge clock_in);
    stby <= 1'b0;
    nmi_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk("notes left", 0, rq.size() + eq.size());
    give_verdict();
  end
endmodule : irab_top_bench
